// [hdl/srft_params.svh]
// Register offsets, reset values and timing figures for the frame timing block
`ifndef SRFT_PARAMS_SVH
`define SRFT_PARAMS_SVH

// Register offsets
`define SRFT_ADDR_WIN_ROWS    8'h03
`define SRFT_ADDR_WIN_WIDTH   8'h04
`define SRFT_ADDR_HBLANK      8'h05
`define SRFT_ADDR_VBLANK      8'h06
`define SRFT_ADDR_INT_ROWS    8'h0B
`define SRFT_ADDR_CTRL        8'h70
`define SRFT_ADDR_STATUS      8'h72
`define SRFT_ADDR_PCLK_CFG    8'h74

// Field positions
`define SRFT_PCLK_INV_BIT     4
`define SRFT_CTRL_EN_BIT      2
`define SRFT_INT_ROWS_MSB     11

// Reset values
`define SRFT_RST_WIN_ROWS     16'h01E0
`define SRFT_RST_WIN_WIDTH    16'h02F0
`define SRFT_RST_HBLANK       16'h005E
`define SRFT_RST_VBLANK       16'h002D
`define SRFT_RST_INT_ROWS     16'h01E0
`define SRFT_RST_CTRL         16'h0000 // Sequencer idle until software enables it
`define SRFT_RST_PCLK_CFG     16'h0000

// Timing figures in pixel clocks or rows
`define SRFT_FEND_TICKS       16'h0017
`define SRFT_VEXT_TICKS       16'h0004
`define SRFT_OVERHEAD_ROWS    16'h0002
`define SRFT_MIN_ROW_TIME     16'h0294
`define SRFT_MIN_HBLANK       16'h002B

`endif

// [hdl/srft_pkg.sv]
// Types shared by the frame timing modules
package srft_pkg;

  typedef enum logic [1:0] {
    SRFT_BIN1,
    SRFT_BIN2,
    SRFT_BIN4
  } srft_bin_t;

  typedef enum logic [2:0] {
    SRFT_S_OFF,
    SRFT_S_FSTART,
    SRFT_S_LINE,
    SRFT_S_HBL,
    SRFT_S_FEND,
    SRFT_S_VBL,
    SRFT_S_VEXT
  } srft_state_t;

  typedef logic [15:0] srft_word_t;
  typedef logic [9:0]  srft_pix_t;

endpackage

// [hdl/srft_cfg_if.sv]
// Configuration and pacing signals between the frame timing modules
`timescale 1ns/10ps
interface srft_cfg_if;
  import srft_pkg::*;

  srft_word_t win_width;
  srft_word_t win_rows;
  srft_word_t hblank;
  srft_word_t vblank;
  srft_word_t int_rows;
  srft_bin_t  bin_sel;
  srft_word_t hb_eff;
  srft_word_t row_time;
  srft_word_t p1_ticks;
  srft_word_t vb_rows;
  logic       long_int;
  logic       tick;
  logic       pclk_lvl;

  modport top  (output win_width, win_rows, hblank, vblank, int_rows, bin_sel,
                input hb_eff, row_time, p1_ticks, vb_rows, long_int, tick, pclk_lvl);
  modport geom (input win_width, win_rows, hblank, vblank, int_rows,
                output hb_eff, row_time, p1_ticks, vb_rows, long_int);
  modport pclk (input bin_sel, output tick, pclk_lvl);
endinterface

// [hdl/srft_pclk.sv]
// Pixel clock divider and pixel pacing tick
`timescale 1ns/10ps
`include "srft_params.svh"
module srft_pclk (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Pacing towards the sequencer
  srft_cfg_if.pclk  cfg
);
  import srft_pkg::*;

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       pclk_lvl;
  logic       next_pclk_lvl;
  logic [1:0] last_phase;

  // Phase count and clock level per binning mode
  always_comb
  begin
    unique case (cfg.bin_sel)
      SRFT_BIN2: last_phase = 2'h1;
      SRFT_BIN4: last_phase = 2'h3;
      default:   last_phase = 2'h0;
    endcase
    next_phase    = (phase >= last_phase) ? 2'h0 : phase + 2'h1;
    // Low in the first half, high in the second half
    next_pclk_lvl = (cfg.bin_sel == SRFT_BIN4) ? next_phase[1] : next_phase[0];
  end

  // Free-running, never gated by blanking
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase    <= 2'h0;
      pclk_lvl <= 1'b0;
    end
    else
    begin
      phase    <= next_phase;
      pclk_lvl <= next_pclk_lvl;
    end
  end

  assign cfg.tick     = (phase >= last_phase);
  assign cfg.pclk_lvl = pclk_lvl;
endmodule

// [hdl/srft_geom.sv]
// Row and frame geometry with minimum row time and long integration
`timescale 1ns/10ps
`include "srft_params.svh"
module srft_geom (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Settings in, geometry out
  srft_cfg_if.geom  cfg
);
  import srft_pkg::*;

  srft_word_t hb_eff;
  srft_word_t next_hb_eff;
  srft_word_t vb_rows;
  srft_word_t next_vb_rows;
  logic       long_int;
  logic       next_long_int;
  srft_word_t hb_min;
  srft_word_t int_rows;
  srft_word_t row_span;

  // Enforced blanking and effective vertical blanking rows
  always_comb
  begin
    // Short windows get extra blanking to reach the row time floor
    if (cfg.win_width + `SRFT_MIN_HBLANK < `SRFT_MIN_ROW_TIME)
      hb_min = `SRFT_MIN_ROW_TIME - cfg.win_width;
    else
      hb_min = `SRFT_MIN_HBLANK;
    next_hb_eff = (cfg.hblank > hb_min) ? cfg.hblank : hb_min;
    int_rows = {4'h0, cfg.int_rows[`SRFT_INT_ROWS_MSB:0]};
    row_span = cfg.win_rows + cfg.vblank;
    // Long integration takes over frame time
    next_long_int = (row_span < `SRFT_OVERHEAD_ROWS) ||
                    (int_rows >= row_span - `SRFT_OVERHEAD_ROWS);
    // Internal stretch only, vblank register untouched
    if (next_long_int)
      next_vb_rows = int_rows + `SRFT_OVERHEAD_ROWS - cfg.win_rows;
    else
      next_vb_rows = cfg.vblank;
  end

  // Registered geometry
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hb_eff   <= `SRFT_RST_HBLANK;
      vb_rows  <= `SRFT_RST_VBLANK;
      long_int <= 1'b0;
    end
    else
    begin
      hb_eff   <= next_hb_eff;
      vb_rows  <= next_vb_rows;
      long_int <= next_long_int;
    end
  end

  assign cfg.hb_eff   = hb_eff;
  assign cfg.row_time = cfg.win_width + hb_eff;
  assign cfg.p1_ticks = hb_eff - `SRFT_FEND_TICKS;
  assign cfg.vb_rows  = vb_rows;
  assign cfg.long_int = long_int;
endmodule

// [hdl/srft_top.sv]
// Frame timing: row and frame qualifiers, pixel clock and register port
//
// How it works
// - Blanking surrounds image; registers set lengths
// - One 10-bit word per pixel clock
// - Normal pixel clock is inverted master clock
// - Bin 2: one cycle high, one low
// - Bin 4: two cycles high, two low
// - Pixel clock never stops, even blanking
// - Polarity bit inverts the pixel clock
// - Frame end 23 clocks; start hblank minus 23
// - Vertical blanking: rows times row time plus 4
// - Frame valid spans rows times row time
// - Long integration decides frame time
// - Long vblank: integration plus 2 minus rows
// - Long frame: integration plus 2 rows plus 4
// - Stretch internal, vblank register unchanged
// - Row time at least 660, hblank 43
`timescale 1ns/10ps
`include "srft_params.svh"
module srft_top (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               nrst_i,
  // Register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire srft_pkg::srft_word_t reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output      srft_pkg::srft_word_t reg_rdata_o,
  // Pixel source from the array readout
  input  wire srft_pkg::srft_pix_t pixel_word_i,
  output      logic               pixel_take_o,
  // Parallel pixel output
  output      logic               pixel_out_clock_o,
  output      logic               line_valid_o,
  output      logic               frame_valid_o,
  output      srft_pkg::srft_pix_t pixel_data_o
);
  import srft_pkg::*;

  srft_cfg_if cfg ();

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register file state
  srft_word_t win_rows;
  srft_word_t win_width;
  srft_word_t hblank;
  srft_word_t vblank;
  srft_word_t int_rows;
  srft_word_t ctrl;
  srft_word_t pclk_cfg;
  srft_word_t rdata;
  srft_word_t next_win_rows;
  srft_word_t next_win_width;
  srft_word_t next_hblank;
  srft_word_t next_vblank;
  srft_word_t next_int_rows;
  srft_word_t next_ctrl;
  srft_word_t next_pclk_cfg;
  srft_word_t next_rdata;

  // Sequencer state
  srft_state_t state;
  srft_state_t next_state;
  srft_word_t  tcnt;
  srft_word_t  next_tcnt;
  srft_word_t  rcnt;
  srft_word_t  next_rcnt;
  srft_word_t  snap_width;
  srft_word_t  snap_hb;
  srft_word_t  snap_p1;
  srft_word_t  snap_rows;
  srft_word_t  snap_vbr;
  srft_word_t  snap_rowt;
  srft_word_t  next_snap_width;
  srft_word_t  next_snap_hb;
  srft_word_t  next_snap_p1;
  srft_word_t  next_snap_rows;
  srft_word_t  next_snap_vbr;
  srft_word_t  next_snap_rowt;
  logic        fv;
  logic        lv;
  logic        take;
  srft_pix_t   pdata;
  logic        next_fv;
  logic        next_lv;
  logic        next_take;
  srft_pix_t   next_pdata;
  logic        enable;
  logic        start_frame;

  // Settings handed to the helpers
  assign cfg.win_width = win_width;
  assign cfg.win_rows  = win_rows;
  assign cfg.hblank    = hblank;
  assign cfg.vblank    = vblank;
  assign cfg.int_rows  = int_rows;
  assign cfg.bin_sel   = (ctrl[1:0] == 2'h1) ? SRFT_BIN2 :
                         (ctrl[1:0] == 2'h2) ? SRFT_BIN4 : SRFT_BIN1;
  assign enable        = ctrl[`SRFT_CTRL_EN_BIT];

  srft_geom u_geom (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .cfg     (cfg.geom)
  );

  srft_pclk u_pclk (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .cfg     (cfg.pclk)
  );

  // Register writes and read data one cycle later
  always_comb
  begin
    next_win_rows  = win_rows;
    next_win_width = win_width;
    next_hblank    = hblank;
    next_vblank    = vblank;
    next_int_rows  = int_rows;
    next_ctrl      = ctrl;
    next_pclk_cfg  = pclk_cfg;
    next_rdata     = 16'h0000;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `SRFT_ADDR_WIN_ROWS:  next_win_rows  = (reg_wdata_i == 16'h0000) ? 16'h0001 : reg_wdata_i;
        `SRFT_ADDR_WIN_WIDTH: next_win_width = (reg_wdata_i == 16'h0000) ? 16'h0001 : reg_wdata_i;
        `SRFT_ADDR_HBLANK:    next_hblank    = reg_wdata_i;
        `SRFT_ADDR_VBLANK:    next_vblank    = reg_wdata_i;
        `SRFT_ADDR_INT_ROWS:  next_int_rows  = reg_wdata_i;
        `SRFT_ADDR_CTRL:      next_ctrl      = {13'h0, reg_wdata_i[2:0]};
        `SRFT_ADDR_PCLK_CFG:  next_pclk_cfg  = reg_wdata_i;
        default:              next_ctrl      = ctrl;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `SRFT_ADDR_WIN_ROWS:  next_rdata = win_rows;
        `SRFT_ADDR_WIN_WIDTH: next_rdata = win_width;
        `SRFT_ADDR_HBLANK:    next_rdata = hblank;
        `SRFT_ADDR_VBLANK:    next_rdata = vblank; // Programmed value only
        `SRFT_ADDR_INT_ROWS:  next_rdata = int_rows;
        `SRFT_ADDR_CTRL:      next_rdata = ctrl;
        `SRFT_ADDR_PCLK_CFG:  next_rdata = pclk_cfg;
        `SRFT_ADDR_STATUS:    next_rdata = {12'h000, cfg.long_int, take, lv, fv};
        default:              next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_rows  <= `SRFT_RST_WIN_ROWS;
      win_width <= `SRFT_RST_WIN_WIDTH;
      hblank    <= `SRFT_RST_HBLANK;
      vblank    <= `SRFT_RST_VBLANK;
      int_rows  <= `SRFT_RST_INT_ROWS;
      ctrl      <= `SRFT_RST_CTRL;
      pclk_cfg  <= `SRFT_RST_PCLK_CFG;
      rdata     <= 16'h0000;
    end
    else
    begin
      win_rows  <= next_win_rows;
      win_width <= next_win_width;
      hblank    <= next_hblank;
      vblank    <= next_vblank;
      int_rows  <= next_int_rows;
      ctrl      <= next_ctrl;
      pclk_cfg  <= next_pclk_cfg;
      rdata     <= next_rdata;
    end
  end

  // Frame sequencer, advanced once per pixel clock period
  always_comb
  begin
    next_state      = state;
    next_tcnt       = tcnt;
    next_rcnt       = rcnt;
    next_snap_width = snap_width;
    next_snap_hb    = snap_hb;
    next_snap_p1    = snap_p1;
    next_snap_rows  = snap_rows;
    next_snap_vbr   = snap_vbr;
    next_snap_rowt  = snap_rowt;
    start_frame     = 1'b0;
    if (cfg.tick)
    begin
      next_tcnt = tcnt + 16'h0001;
      unique case (state)
        SRFT_S_OFF:
          start_frame = enable;
        SRFT_S_FSTART:
          // Frame start blanking before the first row
          if (tcnt >= snap_p1 - 16'h0001)
          begin
            next_state = SRFT_S_LINE;
            next_tcnt  = 16'h0000;
          end
        SRFT_S_LINE:
          if (tcnt >= snap_width - 16'h0001)
          begin
            next_tcnt = 16'h0000;
            next_rcnt = rcnt + 16'h0001;
            // Frame valid covers rows times row time
            next_state = (rcnt >= snap_rows - 16'h0001) ? SRFT_S_FEND : SRFT_S_HBL;
          end
        SRFT_S_HBL:
          // Horizontal blanking between rows
          if (tcnt >= snap_hb - 16'h0001)
          begin
            next_state = SRFT_S_LINE;
            next_tcnt  = 16'h0000;
          end
        SRFT_S_FEND:
          // Fixed frame end blanking after last row
          if (tcnt >= `SRFT_FEND_TICKS - 16'h0001)
          begin
            next_tcnt  = 16'h0000;
            next_rcnt  = 16'h0000;
            next_state = (snap_vbr == 16'h0000) ? SRFT_S_VEXT : SRFT_S_VBL;
          end
        SRFT_S_VBL:
          // Vertical blanking whole rows
          if (tcnt >= snap_rowt - 16'h0001)
          begin
            next_tcnt = 16'h0000;
            next_rcnt = rcnt + 16'h0001;
            if (rcnt >= snap_vbr - 16'h0001)
              next_state = SRFT_S_VEXT;
          end
        SRFT_S_VEXT:
          // Four extra clocks close the vertical blanking
          if (tcnt >= `SRFT_VEXT_TICKS - 16'h0001)
          begin
            start_frame = enable;
            next_state  = SRFT_S_OFF;
          end
      endcase
      if (start_frame)
      begin
        // Geometry is frozen for a whole frame
        next_state      = SRFT_S_FSTART;
        next_tcnt       = 16'h0000;
        next_rcnt       = 16'h0000;
        next_snap_width = win_width;
        next_snap_hb    = cfg.hb_eff;
        next_snap_p1    = cfg.p1_ticks;
        next_snap_rows  = win_rows;
        next_snap_vbr   = cfg.vb_rows;
        next_snap_rowt  = cfg.row_time;
      end
    end
    next_fv    = (next_state == SRFT_S_FSTART) || (next_state == SRFT_S_LINE) ||
                 (next_state == SRFT_S_HBL) || (next_state == SRFT_S_FEND);
    next_lv    = (next_state == SRFT_S_LINE);
    next_take  = cfg.tick && next_lv;
    // One word per period while row valid, zero in blanking
    if (!cfg.tick)
      next_pdata = pdata;
    else if (next_lv)
      next_pdata = pixel_word_i;
    else
      next_pdata = 10'h000;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= SRFT_S_OFF;
      tcnt       <= 16'h0000;
      rcnt       <= 16'h0000;
      snap_width <= `SRFT_RST_WIN_WIDTH;
      snap_hb    <= `SRFT_RST_HBLANK;
      snap_p1    <= `SRFT_RST_HBLANK - `SRFT_FEND_TICKS;
      snap_rows  <= `SRFT_RST_WIN_ROWS;
      snap_vbr   <= `SRFT_RST_VBLANK;
      snap_rowt  <= `SRFT_RST_WIN_WIDTH + `SRFT_RST_HBLANK;
      fv         <= 1'b0;
      lv         <= 1'b0;
      take       <= 1'b0;
      pdata      <= 10'h000;
    end
    else
    begin
      state      <= next_state;
      tcnt       <= next_tcnt;
      rcnt       <= next_rcnt;
      snap_width <= next_snap_width;
      snap_hb    <= next_snap_hb;
      snap_p1    <= next_snap_p1;
      snap_rows  <= next_snap_rows;
      snap_vbr   <= next_snap_vbr;
      snap_rowt  <= next_snap_rowt;
      fv         <= next_fv;
      lv         <= next_lv;
      take       <= next_take;
      pdata      <= next_pdata;
    end
  end

  // Output pins
  assign reg_rdata_o   = rdata;
  assign frame_valid_o = fv;
  assign line_valid_o  = lv;
  assign pixel_data_o  = pdata;
  assign pixel_take_o  = take;

  // Pixel clock: inverted master clock unbinned, divider level otherwise
  always_comb
  begin
    if (cfg.bin_sel == SRFT_BIN1)
      pixel_out_clock_o = ~clk_sys_i ^ pclk_cfg[`SRFT_PCLK_INV_BIT];
    else
      pixel_out_clock_o = cfg.pclk_lvl ^ pclk_cfg[`SRFT_PCLK_INV_BIT];
  end
endmodule

// [dv/srft_top_sva.sv]
// Assertions on the frame timing top module ports
`timescale 1ns/10ps
module srft_top_sva (
  // Clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 nrst_i,
  // Register port
  input wire logic [7:0]           reg_addr_i,
  input wire srft_pkg::srft_word_t reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 reg_rd_i,
  input wire srft_pkg::srft_word_t reg_rdata_o,
  // Pixel side
  input wire srft_pkg::srft_pix_t  pixel_word_i,
  input wire logic                 pixel_take_o,
  input wire logic                 pixel_out_clock_o,
  input wire logic                 line_valid_o,
  input wire logic                 frame_valid_o,
  input wire srft_pkg::srft_pix_t  pixel_data_o
);
  import srft_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  // Read answer stands one cycle; stored words read back
  rdata_idle_a : assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_a : assert property (reg_rd_i && reg_addr_i == 8'h50 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  wr_rd_a : assert property (
    reg_wr_i && reg_addr_i inside {8'h05, 8'h06, 8'h74} ##2 reg_rd_i
    && reg_addr_i == $past(reg_addr_i, 2) |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("register read back differs from write");
  // Blanking carries zero data and rows sit inside the frame
  blank_data_a : assert property (!line_valid_o |-> pixel_data_o == 10'h000)
    else $error("pixel data not zero in blanking");
  lv_in_fv_a : assert property (line_valid_o |-> frame_valid_o)
    else $error("row valid outside frame valid");
  // Each word shown is the one taken from the source
  take_lv_a : assert property (pixel_take_o |-> line_valid_o)
    else $error("word taken outside a row");
  take_data_a : assert property (pixel_take_o |-> pixel_data_o == $past(pixel_word_i))
    else $error("shown word differs from taken word");
  row_start_a : assert property ($rose(line_valid_o) |-> pixel_take_o)
    else $error("row starts without a word");
  // Frame valid leads the first row and trails the last
  fv_lead_a : assert property ($rose(frame_valid_o) |-> !line_valid_o [*8])
    else $error("row too soon after frame start");
  fv_trail_a : assert property ($fell(line_valid_o) |-> frame_valid_o [*8])
    else $error("frame valid falls too soon after a row");
endmodule

// [dv/srft_rx_model.sv]
// Capture receiver model measuring row and frame timing in pixel periods
`timescale 1ns/10ps
module srft_rx_model (
  // Pixel link
  input  wire logic pixel_out_clock_i,
  input  wire logic line_valid_i,
  input  wire logic frame_valid_i,
  // Sample on the falling edge when the clock is inverted
  input  wire logic neg_edge_i,
  // Measurements
  output int        frames_o,
  output int        rises_o,
  output int        rows_o,
  output int        words_o,
  output int        lv_len_o,
  output int        gap_o,
  output int        p1_o,
  output int        p2_o,
  output int        fv_hi_o,
  output int        fv_lo_o
);
  int   tk;
  int   t_fvr;
  int   t_fvf;
  int   t_lvr;
  int   t_lvf;
  bit   fv_q;
  bit   lv_q;
  logic pclk_eff;

  // Latch qualifiers on the rising pixel clock edge, or the falling one when neg_edge_i is set
  assign pclk_eff = pixel_out_clock_i ^ neg_edge_i;

  // Timestamp qualifier edges
  always @(posedge pclk_eff)
  begin
    tk = tk + 1;
    if (frame_valid_i && !fv_q)
    begin
      fv_lo_o = tk - t_fvf;
      t_fvr = tk;
      rows_o = 0;
      words_o = 0;
      rises_o = rises_o + 1;
    end
    if (line_valid_i)
      words_o = words_o + 1;
    if (line_valid_i && !lv_q)
    begin
      if (rows_o == 0)
        p1_o = tk - t_fvr;
      else
        gap_o = tk - t_lvf;
      t_lvr = tk;
    end
    if (!line_valid_i && lv_q)
    begin
      lv_len_o = tk - t_lvr;
      t_lvf = tk;
      rows_o = rows_o + 1;
    end
    if (!frame_valid_i && fv_q)
    begin
      fv_hi_o = tk - t_fvr;
      p2_o = tk - t_lvf;
      t_fvf = tk;
      frames_o = frames_o + 1;
    end
    fv_q = frame_valid_i;
    lv_q = line_valid_i;
  end
endmodule

// [dv/sensor_readout_frame_timing_tb_top.sv]
// Self-checking bench for the frame timing block
`timescale 1ns/10ps
`include "srft_params.svh"
module sensor_readout_frame_timing_tb_top;
  import srft_pkg::*;
  localparam int CYC_MAX = 60000;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  srft_word_t reg_wdata_i = 16'h0000;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  srft_word_t reg_rdata_o;
  srft_pix_t  pixel_word_i = 10'h000;
  logic       pixel_take_o, pixel_out_clock_o, line_valid_o, frame_valid_o;
  srft_pix_t  pixel_data_o;
  logic       rx_neg = 1'b0;
  srft_word_t rd;
  int         frames, rises, rows, words, lv_len, gap, p1, p2, fv_hi, fv_lo;
  int         mismatches, checks, cyc;
  int         ew[1:4], eh[1:4], er[1:4], ev[1:4];

  // Clock, pixel source and hang guard
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) pixel_word_i <= pixel_word_i + 10'h001;
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t timeout", $time);
      close_out;
    end
  end

  srft_top srft_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pixel_word_i(pixel_word_i), .pixel_take_o(pixel_take_o),
    .pixel_out_clock_o(pixel_out_clock_o), .line_valid_o(line_valid_o),
    .frame_valid_o(frame_valid_o), .pixel_data_o(pixel_data_o));
  srft_rx_model srft_rx_model_i (.pixel_out_clock_i(pixel_out_clock_o),
    .line_valid_i(line_valid_o), .frame_valid_i(frame_valid_o), .neg_edge_i(rx_neg),
    .frames_o(frames), .rises_o(rises), .rows_o(rows), .words_o(words), .lv_len_o(lv_len),
    .gap_o(gap), .p1_o(p1), .p2_o(p2), .fv_hi_o(fv_hi), .fv_lo_o(fv_lo));

  // Comparisons and verdict
  task automatic chk_word(input srft_word_t got, input srft_word_t exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    checks = checks + 1;
    if (got != exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Register port cycles
  task automatic wr(input logic [7:0] a, input srft_word_t d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output srft_word_t d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #2;
    d = reg_rdata_o;
  endtask
  task automatic rd_chk(input logic [7:0] a, input srft_word_t exp);
    srft_word_t d;
    rd_reg(a, d);
    chk_word(d, exp);
  endtask

  // Expected geometry of frame k, then program it
  task automatic calc(input int k, r, w, hb, vb, it);
    int he;
    he = (hb > 43) ? hb : 43;
    if (660 - w > he)
      he = 660 - w;
    ew[k] = w;
    eh[k] = he;
    er[k] = r;
    ev[k] = ((it >= r + vb - 2) ? it + 2 - r : vb) * (w + he) + 4;
  endtask
  task automatic cfg(input int k, r, w, hb, vb, it, input srft_word_t ctl, pc);
    calc(k, r, w, hb, vb, it);
    wr(8'h03, 16'(r));
    wr(8'h04, 16'(w));
    wr(8'h05, 16'(hb));
    rd_chk(8'h05, 16'(hb));
    wr(8'h06, 16'(vb));
    wr(8'h0B, 16'(it));
    wr(8'h70, ctl);
    wr(8'h74, pc);
  endtask

  // Measure frame k at its end and, when full is set, its blanking at the next start
  task automatic check_frame(input int k, input bit full);
    wait (frames == k);
    chk_num(rows, er[k]);
    chk_num(words, er[k] * ew[k]);
    chk_num(lv_len, ew[k]);
    chk_num(gap, eh[k]);
    chk_num(p2, 23);
    if (full)
    begin
      chk_num(p1, eh[k] - 23);
      chk_num(fv_hi, er[k] * (ew[k] + eh[k]));
      wait (rises == k + 1);
      chk_num(fv_lo, ev[k]);
    end
    $display("test frame %0d done", k);
  endtask

  // Pixel clock shape, in blanking when n is 1, and aligned to a row start
  task automatic check_pclk(input int n, input logic inv);
    int i;
    if (n == 1)
    begin
      @(posedge clk_sys_i);
      #2;
      chk_word({15'h0, pixel_out_clock_o}, {15'h0, inv});
      @(negedge clk_sys_i);
      #2;
      chk_word({15'h0, pixel_out_clock_o}, {15'h0, ~inv});
    end
    while (line_valid_o !== 1'b0) @(negedge clk_sys_i);
    while (line_valid_o !== 1'b1) @(negedge clk_sys_i);
    // Look after the edge, once the clock mux has settled
    #2;
    for (i = 0; i < 8; i++)
    begin
      chk_word({15'h0, pixel_out_clock_o}, {15'h0, inv ^ ((i % n) >= n / 2)});
      @(negedge clk_sys_i);
      #2;
    end
    $display("test pixel clock %0d done", n);
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(8'h03, `SRFT_RST_WIN_ROWS);
    rd_chk(8'h04, `SRFT_RST_WIN_WIDTH);
    rd_chk(8'h05, `SRFT_RST_HBLANK);
    rd_chk(8'h06, `SRFT_RST_VBLANK);
    rd_chk(8'h0B, `SRFT_RST_INT_ROWS);
    rd_chk(8'h70, `SRFT_RST_CTRL);
    rd_chk(8'h74, `SRFT_RST_PCLK_CFG);
    wr(8'h50, 16'hFFFF);
    rd_chk(8'h50, 16'h0000);
    wr(8'h03, 16'h0000);
    rd_chk(8'h03, 16'h0001);
    $display("test registers done");
    cfg(1, 2, 700, 94, 1, 0, 16'h0004, 16'h0000);
    cfg(2, 2, 640, 43, 1, 0, 16'h0004, 16'h0000);
    check_frame(1, 1);
    check_pclk(1, 1'b0);
    rd_reg(8'h72, rd);
    chk_word(rd & 16'h0008, 16'h0000);
    cfg(3, 2, 100, 560, 1, 10, 16'h0005, 16'h0000);
    check_frame(2, 1);
    check_pclk(2, 1'b0);
    rd_reg(8'h72, rd);
    chk_word(rd & 16'h0008, 16'h0008);
    rd_chk(8'h06, 16'h0001);
    cfg(4, 3, 640, 10, 2, 0, 16'h0006, 16'h0000);
    check_frame(3, 1);
    // Flip polarity in frame start blanking, receiver follows
    wr(8'h74, 16'h0010);
    rx_neg = 1'b1;
    rd_chk(8'h74, 16'h0010);
    check_pclk(4, 1'b1);
    check_frame(4, 0);
    close_out;
  end
endmodule

bind srft_top srft_top_sva srft_top_sva_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pixel_word_i(pixel_word_i),
  .pixel_take_o(pixel_take_o), .pixel_out_clock_o(pixel_out_clock_o),
  .line_valid_o(line_valid_o), .frame_valid_o(frame_valid_o), .pixel_data_o(pixel_data_o));
